//--- flash_guard_pkg.sv
// shared constants and types for the status-register protection block
package flash_guard_pkg;
    // ------------------------------------------------------------
    // status word layout
    // ------------------------------------------------------------
    localparam int STAT_W = 16;
    localparam int ADDR_W = 23;
    localparam int BIT_BUSY = 0;
    localparam int BIT_LATCH = 1;
    localparam int BIT_SIZE_LO = 2;
    localparam int BIT_SIZE_HI = 4;
    localparam int BIT_BOTTOM = 5;
    localparam int BIT_SECTOR = 6;
    localparam int BIT_LOCK_LO = 7;
    localparam int BIT_LOCK_HI = 8;
    localparam int BIT_QUAD = 9;
    localparam int BIT_INVERT = 14;
    localparam int BIT_SUSP = 15;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    // bits that software may write and that survive power cycles
    localparam logic [15:0] NV_MASK = 16'h43fc;
    // ------------------------------------------------------------
    // array geometry
    // ------------------------------------------------------------
    localparam logic [22:0] ARRAY_TOP = 23'h7fffff;
    localparam int BLOCK_SHIFT_BASE = 16;
    localparam int SECTOR_SHIFT_BASE = 11;
    localparam int SECTOR_SHIFT_MAX = 15;
    localparam logic [22:0] PAGE_MASK = 23'h0000ff;
    localparam logic [22:0] SPAN4K_MASK = 23'h000fff;
    localparam logic [22:0] SPAN32K_MASK = 23'h007fff;
    localparam logic [22:0] SPAN64K_MASK = 23'h00ffff;
    localparam logic [1:0] LOCK_SOFT = 2'h0;
    localparam logic [1:0] LOCK_HW = 2'h1;
    localparam logic [1:0] LOCK_POWER = 2'h2;
    localparam logic [1:0] LOCK_OTP = 2'h3;
    localparam int SYNC_STAGES = 2;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CMD_WREN, CMD_WRDI, CMD_WRSR, CMD_SUSPEND, CMD_RESUME, CMD_PROGRAM, CMD_ERASE
    } cmd_kind_t;
    typedef enum logic [2:0] {SPAN_PAGE, SPAN_4K, SPAN_32K, SPAN_64K, SPAN_CHIP} span_t;
    typedef struct packed {
        cmd_kind_t kind;
        span_t span;
        logic [22:0] addr;
        logic [15:0] data;
    } link_cmd_t;
    typedef struct packed {
        logic empty;
        logic [22:0] lo;
        logic [22:0] hi;
    } region_t;
endpackage

//--- cmd_crossing.sv
// toggle-handshake word crossing from the link clock to the system clock
`timescale 1ns/1ns
`default_nettype none
module cmd_crossing #(
    parameter int WIDTH = 45
) (
    // source side, link clock
    input wire logic i_src_clk,
    input wire logic i_arst_n,
    input wire logic i_src_valid,
    input wire logic [WIDTH-1:0] i_src_data,
    output logic o_src_ready,
    // destination side, system clock
    input wire logic i_dst_clk,
    output logic o_dst_valid,
    output logic [WIDTH-1:0] o_dst_data
);
    logic req_q;
    logic [WIDTH-1:0] hold_q;
    logic ack_meta_q;
    logic ack_sync_q;
    logic req_meta_q;
    logic req_sync_q;
    logic req_seen_q;
    logic ack_q;

    // ------------------------------------------------------------
    // source side
    // ------------------------------------------------------------
    // one word in flight; hold stays stable until the ack returns
    assign o_src_ready = (req_q == ack_sync_q);

    always_ff @(posedge i_src_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            req_q <= 1'b0;
            hold_q <= '0;
        end else if (i_src_valid && o_src_ready) begin
            req_q <= ~req_q;
            hold_q <= i_src_data;
        end
    end

    always_ff @(posedge i_src_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_meta_q <= 1'b0;
            ack_sync_q <= 1'b0;
        end else begin
            ack_meta_q <= ack_q;
            ack_sync_q <= ack_meta_q;
        end
    end

    // ------------------------------------------------------------
    // destination side
    // ------------------------------------------------------------
    always_ff @(posedge i_dst_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            req_meta_q <= 1'b0;
            req_sync_q <= 1'b0;
            req_seen_q <= 1'b0;
        end else begin
            req_meta_q <= req_q;
            req_sync_q <= req_meta_q;
            req_seen_q <= req_sync_q;
        end
    end

    always_ff @(posedge i_dst_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_q <= 1'b0;
            o_dst_valid <= 1'b0;
            o_dst_data <= '0;
        end else begin
            o_dst_valid <= (req_sync_q != req_seen_q);
            if (req_sync_q != req_seen_q) begin
                ack_q <= req_sync_q;
                o_dst_data <= hold_q;
            end
        end
    end
endmodule
`default_nettype wire

//--- flash_status_guard.sv
// status-register write lock and array protection decode of a serial flash
`timescale 1ns/1ns
`default_nettype none
module flash_status_guard
    import flash_guard_pkg::*;
(
    // system clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // link clock domain command port
    input wire logic i_link_clk,
    input wire logic i_cmd_valid,
    input wire flash_guard_pkg::link_cmd_t i_cmd,
    output logic o_cmd_ready,
    // pins
    input wire logic i_wp_pin,
    output logic o_wp_enable,
    output logic o_pause_enable,
    // non-volatile store
    input wire logic [15:0] i_nv_image,
    output logic [15:0] o_nv_image,
    output logic o_nv_store,
    // array engine
    input wire logic i_busy,
    output logic [15:0] o_status_word,
    output logic o_pe_go,
    output logic o_pe_block,
    output logic o_wrsr_taken,
    output logic o_wrsr_refused
);
    import flash_guard_pkg::*;

    typedef enum {ST_LOAD, ST_RUN} phase_t;

    phase_t phase_q;
    logic cmd_v;
    link_cmd_t cmd;
    logic wp_meta_q;
    logic wp_sync_q;
    logic [15:0] nv_q;
    logic latch_q;
    logic susp_q;
    logic [1:0] lock_mode;
    logic wp_level;
    logic wrsr_allow;
    logic pe_hit;
    logic is_wrsr;
    logic is_pe;
    region_t span_r;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic region_t guard_region(input logic [15:0] nv);
        region_t r;
        logic [2:0] code;
        int unsigned n;
        logic [22:0] mask;
        code = nv[BIT_SIZE_HI:BIT_SIZE_LO];
        if (nv[BIT_SECTOR]) begin
            // codes 100 to 110 give the 32KB sector span; 111 covers the whole array
            n = (code >= 3'h4) ? SECTOR_SHIFT_MAX : SECTOR_SHIFT_BASE + 32'(code);
        end else begin
            n = BLOCK_SHIFT_BASE + 32'(code);
        end
        mask = 23'((24'h1 << n) - 24'h1);
        r.empty = (code == 3'h0);
        if (code == 3'h7) begin
            r.lo = '0;
            r.hi = ARRAY_TOP;
        end else if (nv[BIT_BOTTOM]) begin
            r.lo = '0;
            r.hi = mask;
        end else begin
            r.lo = ~mask;
            r.hi = ARRAY_TOP;
        end
        return r;
    endfunction

    function automatic region_t span_region(input link_cmd_t c);
        region_t r;
        logic [22:0] mask;
        unique case (c.span)
            SPAN_PAGE: mask = PAGE_MASK;
            SPAN_4K: mask = SPAN4K_MASK;
            SPAN_32K: mask = SPAN32K_MASK;
            SPAN_64K: mask = SPAN64K_MASK;
            default: mask = ARRAY_TOP;
        endcase
        r.empty = 1'b0;
        r.lo = c.addr & ~mask;
        r.hi = c.addr | mask;
        return r;
    endfunction

    function automatic logic touches_guard(input logic [15:0] nv, input region_t s);
        region_t g;
        g = guard_region(nv);
        if (nv[BIT_INVERT]) begin
            return g.empty || (s.lo < g.lo) || (s.hi > g.hi);
        end
        return !g.empty && (s.lo <= g.hi) && (s.hi >= g.lo);
    endfunction

    // ------------------------------------------------------------
    // link crossing
    // ------------------------------------------------------------
    cmd_crossing #(
        .WIDTH($bits(link_cmd_t))
    ) u_crossing (
        .i_src_clk(i_link_clk),
        .i_arst_n(i_arst_n),
        .i_src_valid(i_cmd_valid),
        .i_src_data(i_cmd),
        .o_src_ready(o_cmd_ready),
        .i_dst_clk(i_sys_clk),
        .o_dst_valid(cmd_v),
        .o_dst_data(cmd)
    );

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            wp_meta_q <= 1'b0;
            wp_sync_q <= 1'b0;
        end else begin
            wp_meta_q <= i_wp_pin;
            wp_sync_q <= wp_meta_q;
        end
    end

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    assign lock_mode = {nv_q[BIT_LOCK_HI], nv_q[BIT_LOCK_LO]};
    // with the quad bit set the pin carries data, so it no longer locks
    assign wp_level = nv_q[BIT_QUAD] ? 1'b1 : wp_sync_q;
    assign is_wrsr = cmd_v && (phase_q == ST_RUN) && (cmd.kind == CMD_WRSR);
    assign is_pe = cmd_v && (phase_q == ST_RUN)
        && (cmd.kind == CMD_PROGRAM || cmd.kind == CMD_ERASE);
    assign span_r = span_region(cmd);
    assign pe_hit = touches_guard(nv_q, span_r);

    always_comb begin
        unique case (lock_mode)
            LOCK_SOFT: wrsr_allow = latch_q;
            LOCK_HW: wrsr_allow = latch_q && wp_level;
            LOCK_POWER: wrsr_allow = 1'b0;
            LOCK_OTP: wrsr_allow = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // power-up load and status bits
    // ------------------------------------------------------------
    // one load cycle; the crossing needs at least three edges, so no command is lost
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            phase_q <= ST_LOAD;
        end else begin
            phase_q <= ST_RUN;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            nv_q <= STATUS_RESET;
        end else if (phase_q == ST_LOAD) begin
            nv_q <= i_nv_image & NV_MASK;
            if ({i_nv_image[BIT_LOCK_HI], i_nv_image[BIT_LOCK_LO]} == LOCK_POWER) begin
                nv_q[BIT_LOCK_HI] <= 1'b0;
                nv_q[BIT_LOCK_LO] <= 1'b0;
            end
        end else if (is_wrsr && wrsr_allow) begin
            nv_q <= cmd.data & NV_MASK;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            latch_q <= 1'b0;
        end else if (cmd_v && phase_q == ST_RUN) begin
            unique case (cmd.kind)
                CMD_WREN: latch_q <= 1'b1;
                CMD_WRDI: latch_q <= 1'b0;
                CMD_WRSR: latch_q <= wrsr_allow ? 1'b0 : latch_q;
                CMD_PROGRAM, CMD_ERASE: latch_q <= (latch_q && !pe_hit) ? 1'b0 : latch_q;
                default: latch_q <= latch_q;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            susp_q <= 1'b0;
        end else if (cmd_v && phase_q == ST_RUN && cmd.kind == CMD_SUSPEND) begin
            susp_q <= 1'b1;
        end else if (cmd_v && phase_q == ST_RUN && cmd.kind == CMD_RESUME) begin
            susp_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_status_word <= STATUS_RESET;
            o_wp_enable <= 1'b1;
            o_pause_enable <= 1'b1;
        end else begin
            o_status_word <= nv_q;
            o_status_word[BIT_BUSY] <= i_busy;
            o_status_word[BIT_LATCH] <= latch_q;
            o_status_word[BIT_SUSP] <= susp_q;
            o_wp_enable <= !nv_q[BIT_QUAD];
            o_pause_enable <= !nv_q[BIT_QUAD];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_wrsr_taken <= 1'b0;
            o_wrsr_refused <= 1'b0;
            o_nv_store <= 1'b0;
            o_nv_image <= STATUS_RESET;
        end else begin
            o_wrsr_taken <= is_wrsr && wrsr_allow;
            o_wrsr_refused <= is_wrsr && !wrsr_allow;
            o_nv_store <= is_wrsr && wrsr_allow;
            if (is_wrsr && wrsr_allow) begin
                o_nv_image <= cmd.data & NV_MASK;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_pe_go <= 1'b0;
            o_pe_block <= 1'b0;
        end else begin
            o_pe_go <= is_pe && latch_q && !pe_hit;
            o_pe_block <= is_pe && (pe_hit || !latch_q);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);

    refused_keeps_a: assert property (is_wrsr && !wrsr_allow |=>
        nv_q == $past(nv_q) && latch_q == $past(latch_q))
        else $error("refused status write changed state");
    hw_pin_low_a: assert property (is_wrsr && lock_mode == LOCK_HW && !wp_level
        |=> o_wrsr_refused && !o_wrsr_taken ##1 !o_nv_store)
        else $error("status write taken with pin low");
    soft_accept_a: assert property (is_wrsr && lock_mode == LOCK_SOFT && latch_q
        |=> o_wrsr_taken ##1 o_status_word[BIT_LATCH] == 1'b0)
        else $error("soft mode write not taken");
    latch_needed_a: assert property (is_wrsr && lock_mode == LOCK_HW && !latch_q
        |=> o_wrsr_refused)
        else $error("status write taken without latch");
    otp_sticks_a: assert property (phase_q == ST_RUN && lock_mode == LOCK_OTP
        |=> lock_mode == LOCK_OTP)
        else $error("one-time lock left");
    power_unlock_a: assert property (phase_q == ST_LOAD
        && {i_nv_image[BIT_LOCK_HI], i_nv_image[BIT_LOCK_LO]} == LOCK_POWER
        |=> lock_mode == LOCK_SOFT ##1 o_status_word[BIT_LOCK_HI:BIT_LOCK_LO] == 2'h0)
        else $error("power lock survived load");
    suspend_flag_a: assert property (cmd_v && phase_q == ST_RUN && cmd.kind == CMD_SUSPEND
        |=> ##1 o_status_word[BIT_SUSP])
        else $error("suspend flag not shown");
    resume_flag_a: assert property (cmd_v && phase_q == ST_RUN && cmd.kind == CMD_RESUME
        |=> ##1 !o_status_word[BIT_SUSP])
        else $error("suspend flag not cleared");
    protected_block_a: assert property (is_pe && pe_hit
        |=> o_pe_block && !o_pe_go)
        else $error("protected program or erase let through");
    full_array_a: assert property (is_pe && !nv_q[BIT_INVERT]
        && nv_q[BIT_SIZE_HI:BIT_SIZE_LO] == 3'h7 |=> o_pe_block)
        else $error("all-array protection missed");
    invert_all_a: assert property (is_pe && nv_q[BIT_INVERT]
        && nv_q[BIT_SIZE_HI:BIT_SIZE_LO] == 3'h0 |=> o_pe_block)
        else $error("inverted empty code not protecting all");
    bottom_sector_a: assert property (is_pe && !nv_q[BIT_INVERT] && nv_q[BIT_SECTOR]
        && nv_q[BIT_BOTTOM] && nv_q[BIT_SIZE_HI:BIT_SIZE_LO] == 3'h1
        && cmd.span == SPAN_PAGE && cmd.addr < 23'h001000 |=> o_pe_block)
        else $error("bottom sector left open");
    quad_pins_a: assert property ($rose(nv_q[BIT_QUAD]) |=> !o_pause_enable && !o_wp_enable)
        else $error("control pins still active in quad mode");

    wrsr_taken_c: cover property (is_wrsr && wrsr_allow);
    wrsr_refused_c: cover property (is_wrsr && !wrsr_allow);
    pe_go_c: cover property (o_pe_go);
    pe_block_c: cover property (o_pe_block);
endmodule
`default_nettype wire

//--- host_link_model.sv
// host controller model that issues commands on the link port
`timescale 1ns/1ns
`default_nettype none
module host_link_model (
    // link side
    input wire logic i_link_clk,
    input wire logic i_ready,
    output logic o_valid,
    output flash_guard_pkg::link_cmd_t o_cmd
);
    import flash_guard_pkg::*;

    initial begin
        o_valid = 1'b0;
        o_cmd = '0;
    end

    // ------------------------------------------------------------
    // one command: offer, hold until taken, wait for ready again
    // ------------------------------------------------------------
    // lag lets the host answer promptly or slowly
    task automatic send(input link_cmd_t c, input int lag);
        int n;
        n = 0;
        repeat (lag + 1) @(posedge i_link_clk);
        o_valid <= 1'b1;
        o_cmd <= c;
        do @(posedge i_link_clk); while (!i_ready && n++ < 200);
        o_valid <= 1'b0;
        // released bus shows the inverse so a stale word never looks held
        o_cmd <= ~c;
        do @(posedge i_link_clk); while (!i_ready && n++ < 400);
    endtask
endmodule
`default_nettype wire

//--- flash_status_write_protect_tb_top.sv
// self-checking bench for the status-register protection block
`timescale 1ns/1ns
`default_nettype none
module flash_status_write_protect_tb_top;
    import flash_guard_pkg::*;

    logic i_sys_clk = 1'b0;
    logic i_link_clk = 1'b0;
    logic i_arst_n = 1'b0;
    logic i_wp_pin = 1'b0;
    logic i_busy = 1'b0;
    logic [15:0] i_nv_image = 16'h0000;
    logic cmd_valid, cmd_ready, wp_enable, pause_enable, nv_store;
    logic pe_go, pe_block, wrsr_taken, wrsr_refused;
    link_cmd_t cmd;
    logic [15:0] nv_image_out, status_word;
    logic [15:0] nv = 16'h0000;
    logic [15:0] nv_mem = 16'h0000;
    logic [15:0] lfsr = 16'h0013;
    logic latch = 1'b0;
    logic susp = 1'b0;
    logic [17:0] e;
    logic [17:0] expq[$];
    int n_mismatch = 0;
    int checks_done = 0;

    always #2 i_sys_clk = ~i_sys_clk;
    always #15 i_link_clk = ~i_link_clk;

    flash_status_guard i_dut (
        .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_link_clk(i_link_clk),
        .i_cmd_valid(cmd_valid), .i_cmd(cmd), .o_cmd_ready(cmd_ready),
        .i_wp_pin(i_wp_pin), .o_wp_enable(wp_enable), .o_pause_enable(pause_enable),
        .i_nv_image(i_nv_image), .o_nv_image(nv_image_out), .o_nv_store(nv_store),
        .i_busy(i_busy), .o_status_word(status_word), .o_pe_go(pe_go),
        .o_pe_block(pe_block), .o_wrsr_taken(wrsr_taken), .o_wrsr_refused(wrsr_refused)
    );

    host_link_model i_host (
        .i_link_clk(i_link_clk), .i_ready(cmd_ready), .o_valid(cmd_valid), .o_cmd(cmd)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // true when the span touches a protected byte
    function automatic logic hits(input logic [15:0] s, input logic [22:0] lo,
                                  input logic [22:0] hi);
        logic [23:0] sz, rlo, rhi;
        logic [2:0] c;
        c = s[4:2];
        if (!s[6]) sz = 24'h1 << (16 + c);
        else sz = 24'h1 << (11 + ((c > 3'h3) ? 3'h4 : c));
        rlo = s[5] ? 24'h000000 : 24'h800000 - sz;
        rhi = s[5] ? sz - 24'h1 : 24'h7fffff;
        // empty region: lo above every address
        if (c == 3'h0) rlo = 24'h800000;
        if (c == 3'h7) begin
            rlo = 24'h000000;
            rhi = 24'h7fffff;
        end
        if (!s[14]) return ({1'b0, lo} <= rhi) && ({1'b0, hi} >= rlo);
        return !(({1'b0, lo} >= rlo) && ({1'b0, hi} <= rhi));
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // pin is driven, never tied, so quad mode may be set safely
    task automatic pin(input logic v);
        @(posedge i_sys_clk);
        i_wp_pin <= v;
        repeat (3) @(posedge i_sys_clk);
    endtask

    task automatic issue(input cmd_kind_t k, input span_t sp, input logic [22:0] a,
                         input logic [15:0] d);
        link_cmd_t c;
        logic [22:0] m;
        lfsr = step(lfsr);
        // junk in the bits that are never stored
        c = '{kind: k, span: sp, addr: a, data: d | (lfsr & ~NV_MASK)};
        m = (sp == SPAN_PAGE) ? PAGE_MASK : (sp == SPAN_4K) ? SPAN4K_MASK :
            (sp == SPAN_32K) ? SPAN32K_MASK : (sp == SPAN_64K) ? SPAN64K_MASK : ARRAY_TOP;
        case (k)
            CMD_WREN: latch = 1'b1;
            CMD_WRDI: latch = 1'b0;
            CMD_SUSPEND: susp = 1'b1;
            CMD_RESUME: susp = 1'b0;
            CMD_WRSR: begin
                if (latch && (nv[8:7] == LOCK_SOFT ||
                    (nv[8:7] == LOCK_HW && (i_wp_pin || nv[9])))) begin
                    nv = d & NV_MASK;
                    latch = 1'b0;
                    expq.push_back({2'h0, nv});
                end else begin
                    expq.push_back({2'h1, 16'h0000});
                end
            end
            default: begin
                if (latch && !hits(nv, a & ~m, a | m)) begin
                    latch = 1'b0;
                    expq.push_back({2'h2, 16'h0000});
                end else begin
                    expq.push_back({2'h3, 16'h0000});
                end
            end
        endcase
        i_host.send(c, int'(lfsr[1:0]));
        repeat (4) @(posedge i_sys_clk);
        check("status", status_word, nv | {susp, 13'h0000, latch, i_busy});
        check("pin mode", {wp_enable, pause_enable}, {2{~nv[9]}});
    endtask

    task automatic wr_status(input logic [15:0] d);
        issue(CMD_WREN, SPAN_PAGE, 23'h000000, 16'h0000);
        issue(CMD_WRSR, SPAN_PAGE, 23'h000000, d);
    endtask

    task automatic power_cycle();
        @(posedge i_sys_clk);
        i_arst_n <= 1'b0;
        i_nv_image <= nv_mem | (lfsr & ~NV_MASK);
        repeat (12) @(posedge i_sys_clk);
        repeat (2) @(posedge i_link_clk);
        @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        nv = nv_mem & NV_MASK;
        if (nv[8:7] == LOCK_POWER) nv[8:7] = LOCK_SOFT;
        latch = 1'b0;
        susp = 1'b0;
        repeat (4) @(posedge i_sys_clk);
        check("status after power", status_word, nv | {15'h0000, i_busy});
        check("ready after power", cmd_ready, 1'b1);
        check("pin mode", {wp_enable, pause_enable}, {2{~nv[9]}});
    endtask

    // ------------------------------------------------------------
    // result monitor
    // ------------------------------------------------------------
    always @(posedge i_sys_clk) begin
        if (nv_store) nv_mem <= nv_image_out;
        if (wrsr_taken | wrsr_refused | pe_go | pe_block) begin
            if (expq.size() == 0) begin
                check("unexpected result", {wrsr_taken, wrsr_refused, pe_go, pe_block}, 0);
            end else begin
                e = expq.pop_front();
                check("result", {wrsr_taken, wrsr_refused, pe_go, pe_block},
                      4'h8 >> e[17:16]);
                if (e[17:16] == 2'h0) check("stored image", {nv_store, nv_image_out},
                                             {1'b1, e[15:0]});
            end
        end
    end

    initial begin
        #300000;
        n_mismatch++;
        conclude();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        power_cycle();
        issue(CMD_WRSR, SPAN_PAGE, 23'h000000, 16'h0080);
        wr_status(16'h0080);
        wr_status(16'h0000);
        pin(1'b1);
        issue(CMD_WRSR, SPAN_PAGE, 23'h000000, 16'h0280);
        // latch was spent by the write above, so this one must be refused
        issue(CMD_WRSR, SPAN_PAGE, 23'h000000, 16'h0000);
        pin(1'b0);
        wr_status(16'h0100);
        wr_status(16'h0000);
        power_cycle();
        for (int i = 0; i < 64; i++) begin
            lfsr = step(lfsr);
            pin(lfsr[4]);
            wr_status({1'b0, i[5], 7'h00, i[4], i[3], i[2:0], 2'h0});
            issue(CMD_WREN, SPAN_PAGE, 23'h000000, 16'h0000);
            issue(CMD_ERASE, span_t'(lfsr[2:0] % 3'h5), lfsr[3] ? ARRAY_TOP : 23'h000000,
                  16'h0000);
            issue(CMD_WREN, SPAN_PAGE, 23'h000000, 16'h0000);
            issue(CMD_PROGRAM, SPAN_PAGE, {lfsr[6:0], lfsr}, 16'h0000);
        end
        // bottom 4KB sector: one page inside, one just past the edge
        wr_status(16'h0064);
        issue(CMD_WREN, SPAN_PAGE, 23'h000000, 16'h0000);
        issue(CMD_PROGRAM, SPAN_PAGE, 23'h000800, 16'h0000);
        issue(CMD_PROGRAM, SPAN_PAGE, 23'h001000, 16'h0000);
        wr_status(16'h0000);
        issue(CMD_WREN, SPAN_PAGE, 23'h000000, 16'h0000);
        issue(CMD_WRDI, SPAN_PAGE, 23'h000000, 16'h0000);
        issue(CMD_ERASE, SPAN_CHIP, 23'h000000, 16'h0000);
        @(posedge i_sys_clk);
        i_busy <= 1'b1;
        issue(CMD_SUSPEND, SPAN_PAGE, 23'h000000, 16'h0000);
        issue(CMD_RESUME, SPAN_PAGE, 23'h000000, 16'h0000);
        issue(CMD_SUSPEND, SPAN_PAGE, 23'h000000, 16'h0000);
        power_cycle();
        i_busy <= 1'b0;
        wr_status(16'h0180);
        wr_status(16'h0000);
        power_cycle();
        wr_status(16'h0000);
        conclude();
    end
endmodule
`default_nettype wire
